// File: src/vdrt_defines.vh
// How it works
// - Enabled and voltage below third recovery level raises the event flag.
// - During event, suppress low-voltage shutdown and trip while above curve.
// - Below curve during event, raise low-voltage alarm after transient delay.
// - Clear event only after final interval expired and voltage above third level.
// - Still below third level at final expiry keeps the event flag set.
// - After unrecovered expiry suppress nothing until recovery and a fresh event.
// - Curve is voltages rising at successive intervals from event start.
// - Five curve voltages and five intervals are held as settings.
// - Active event also masks the listed protection trip and shutdown alarms.
// - Warning alarms, low-voltage warning included, are never suppressed.
// - Event counter increments each time the function activates.
// - Counter is readable and returns to zero on a commanded reset.
// - Mode selects operation in mains parallel, generator parallel, or both.
`ifndef VDRT_DEFINES_VH
`define VDRT_DEFINES_VH
`define VDRT_CTRL 8'h00
`define VDRT_STATUS 8'h04
`define VDRT_MASK 8'h08
`define VDRT_VOLT 8'h0c
`define VDRT_COUNT 8'h10
`define VDRT_TDELAY 8'h14
`define VDRT_V0 8'h20
`define VDRT_T0 8'h40
`define VDRT_CTRL_EN 0
`define VDRT_CTRL_MAINS 1
`define VDRT_CTRL_GENS 2
`define VDRT_CTRL_CLRCNT 3
`define VDRT_CTRL_RESET 32'h0000_0006
`define VDRT_TICK_NS 1000
`define VDRT_CLK_NS 4
`define VDRT_TICK_CYC (`VDRT_TICK_NS / `VDRT_CLK_NS)
`endif

// File: src/vdrt_top.v
// Local design decisions: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "vdrt_defines.vh"
module vdrt_top (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite slave
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Measurement and system state, same clock domain
    input wire [15:0] gen_voltage,
    input wire mains_parallel,
    input wire gens_parallel,
    input wire gen_low_voltage_cond,
    input wire [15:0] trip_alarm_cond,
    // Outputs
    output reg event_active,
    output reg gen_low_voltage_alarm,
    output reg suppress_low_voltage,
    output reg [15:0] trip_suppress_mask,
    output reg [15:0] warning_suppress_mask,
    output wire [15:0] trip_alarm_out,
    output wire irq
);
    reg [31:0] ctrl_reg;
    reg [1:0] status_reg;
    reg [1:0] mask_reg;
    reg [15:0] volt_reg [0:4];
    reg [15:0] intv_reg [0:4];
    reg [31:0] tdelay_reg;
    reg [31:0] count_reg;
    reg [31:0] tick_reg;
    reg [31:0] ms_reg;
    reg [31:0] td_reg;
    reg latched_reg;
    reg [15:0] thr;
    reg [2:0] step;
    integer i;
    // The reset loop has its own index so that no variable is driven from two processes.
    integer j;
    reg aw_hold, w_hold;
    reg [7:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    wire [15:0] rec3 = volt_reg[4];
    wire allowed = (ctrl_reg[`VDRT_CTRL_MAINS] & mains_parallel) |
        (ctrl_reg[`VDRT_CTRL_GENS] & gens_parallel);
    wire enabled = ctrl_reg[`VDRT_CTRL_EN] & allowed;
    wire below3 = gen_voltage < rec3;
    wire final_done = ms_reg >= {16'h0, intv_reg[4]};
    wire start_ev = enabled & below3 & ~event_active & ~latched_reg;
    wire below_curve = gen_voltage < thr;
    wire do_wr = aw_hold & w_hold & ~s_axi_bvalid;
    // Step curve: each interval is cumulative time from event start.
    always @* begin
        thr = volt_reg[0];
        step = 3'd0;
        for (i = 1; i < 5; i = i + 1) begin
            if (ms_reg >= {16'h0, intv_reg[i-1]}) begin
                thr = volt_reg[i];
                step = i[2:0];
            end
        end
    end
    assign s_axi_awready = ~aw_hold;
    assign s_axi_wready = ~w_hold;
    assign s_axi_arready = ~s_axi_rvalid;
    assign trip_alarm_out = trip_alarm_cond & ~trip_suppress_mask;
    assign irq = |(status_reg & mask_reg);
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= `VDRT_CTRL_RESET;
            status_reg <= 2'h0;
            mask_reg <= 2'h0;
            for (j = 0; j < 5; j = j + 1) begin
                volt_reg[j] <= 16'h0;
                intv_reg[j] <= 16'h0;
            end
            tdelay_reg <= 32'h0;
            count_reg <= 32'h0;
            tick_reg <= 32'h0;
            ms_reg <= 32'h0;
            td_reg <= 32'h0;
            latched_reg <= 1'b0;
            event_active <= 1'b0;
            gen_low_voltage_alarm <= 1'b0;
            suppress_low_voltage <= 1'b0;
            trip_suppress_mask <= 16'h0;
            warning_suppress_mask <= 16'h0;
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= 8'h0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'b00;
        end else begin
            if (s_axi_awvalid && !aw_hold) begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_hold) begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            ctrl_reg[`VDRT_CTRL_CLRCNT] <= 1'b0;
            if (do_wr) begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'b00;
                // Partial strobes are rejected with SLVERR; only full-word writes are decoded, to keep decode small.
                if (w_strb != 4'hf)
                    s_axi_bresp <= 2'b10;
                else begin
                    case (aw_addr)
                        `VDRT_CTRL: ctrl_reg <= {28'h0, w_data[3:0]};
                        `VDRT_MASK: mask_reg <= w_data[1:0];
                        `VDRT_TDELAY: tdelay_reg <= w_data;
                        `VDRT_STATUS: ;
                        default: begin
                            if (aw_addr >= `VDRT_V0 && aw_addr < `VDRT_V0 + 8'd20 &&
                                aw_addr[1:0] == 2'b00)
                                volt_reg[aw_addr[4:2]] <= w_data[15:0];
                            else if (aw_addr >= `VDRT_T0 && aw_addr < `VDRT_T0 + 8'd20 &&
                                aw_addr[1:0] == 2'b00)
                                intv_reg[aw_addr[4:2]] <= w_data[15:0];
                            else
                                s_axi_bresp <= 2'b10;
                        end
                    endcase
                end
            end
            if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
            if (s_axi_arvalid && !s_axi_rvalid) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'b00;
                s_axi_rdata <= 32'h0;
                case (s_axi_araddr)
                    `VDRT_CTRL: s_axi_rdata <= ctrl_reg;
                    `VDRT_STATUS: s_axi_rdata <= {27'h0, step, status_reg};
                    `VDRT_MASK: s_axi_rdata <= {30'h0, mask_reg};
                    `VDRT_VOLT: s_axi_rdata <= {13'h0, latched_reg, gen_low_voltage_alarm,
                        event_active, gen_voltage};
                    `VDRT_COUNT: s_axi_rdata <= count_reg;
                    `VDRT_TDELAY: s_axi_rdata <= tdelay_reg;
                    default: begin
                        if (s_axi_araddr >= `VDRT_V0 && s_axi_araddr < `VDRT_V0 + 8'd20 &&
                            s_axi_araddr[1:0] == 2'b00)
                            s_axi_rdata <= {16'h0, volt_reg[s_axi_araddr[4:2]]};
                        else if (s_axi_araddr >= `VDRT_T0 && s_axi_araddr < `VDRT_T0 + 8'd20 &&
                            s_axi_araddr[1:0] == 2'b00)
                            s_axi_rdata <= {16'h0, intv_reg[s_axi_araddr[4:2]]};
                        else
                            s_axi_rresp <= 2'b10;
                    end
                endcase
            end
            // Microsecond timebase (1000 ns tick) runs only inside an event.
            if (event_active) begin
                if (tick_reg == `VDRT_TICK_CYC - 1) begin
                    tick_reg <= 32'h0;
                    if (!final_done)
                        ms_reg <= ms_reg + 32'd1;
                end else
                    tick_reg <= tick_reg + 32'd1;
            end else begin
                tick_reg <= 32'h0;
                ms_reg <= 32'h0;
            end
            if (start_ev) begin
                event_active <= 1'b1;
                if (ctrl_reg[`VDRT_CTRL_CLRCNT] == 1'b0)
                    count_reg <= count_reg + 32'd1;
            end else if (event_active && final_done) begin
                if (!below3) begin
                    event_active <= 1'b0;
                    latched_reg <= 1'b0;
                end else
                    latched_reg <= 1'b1;
            end
            if (ctrl_reg[`VDRT_CTRL_CLRCNT])
                count_reg <= 32'h0;
            // Held-low state after expiry waits for recovery before a new event may start.
            if (!event_active && latched_reg && !below3)
                latched_reg <= 1'b0;
            if (event_active && !latched_reg && !final_done) begin
                suppress_low_voltage <= ~below_curve;
                trip_suppress_mask <= 16'hffff;
            end else begin
                suppress_low_voltage <= 1'b0;
                trip_suppress_mask <= 16'h0;
            end
            warning_suppress_mask <= 16'h0;
            if (event_active && below_curve && !latched_reg) begin
                if (td_reg >= tdelay_reg)
                    gen_low_voltage_alarm <= 1'b1;
                else
                    td_reg <= td_reg + 32'd1;
            end else begin
                td_reg <= 32'h0;
                if (!event_active)
                    gen_low_voltage_alarm <= 1'b0;
            end
            // Sticky status: a new event beats a clear written in the same cycle.
            if (do_wr && w_strb == 4'hf && aw_addr == `VDRT_STATUS)
                status_reg <= status_reg & ~w_data[1:0];
            if (start_ev)
                status_reg[0] <= 1'b1;
            if (event_active && !gen_low_voltage_alarm && below_curve && !latched_reg &&
                td_reg >= tdelay_reg)
                status_reg[1] <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// File: tb/vdrt_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module vdrt_asserts (
    // Clock, reset and bus handshakes
    input wire logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
    input wire logic s_axi_wready, s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid,
    // Ride-through outputs and the trip alarm input
    input wire logic event_active, gen_low_voltage_alarm, suppress_low_voltage,
    input wire logic [15:0] trip_alarm_cond, trip_suppress_mask, warning_suppress_mask,
    input wire logic [15:0] trip_alarm_out
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_warn; warning_suppress_mask == 16'h0000; endproperty
    a_warn: assert property (p_warn) else $error("warning mask set");
    property p_out; trip_alarm_out == (trip_alarm_cond & ~trip_suppress_mask); endproperty
    a_out: assert property (p_out) else $error("trip output not masked");
    property p_full; trip_suppress_mask == 16'h0000 || trip_suppress_mask == 16'hffff; endproperty
    a_full: assert property (p_full) else $error("partial trip mask");
    property p_sup; suppress_low_voltage |-> event_active; endproperty
    a_sup: assert property (p_sup) else $error("suppress without event");
    property p_mevt; trip_suppress_mask != 16'h0000 |-> event_active; endproperty
    a_mevt: assert property (p_mevt) else $error("mask without event");
    property p_end; $fell(event_active) |-> ##[0:1] !gen_low_voltage_alarm; endproperty
    a_end: assert property (p_end) else $error("alarm outlives event");
    property p_ar; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_ar: assert property (p_ar) else $error("late read answer");
    property p_b;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_b: assert property (p_b) else $error("late write answer");
    cover property ($rose(event_active));
    cover property ($rose(gen_low_voltage_alarm));
    cover property ($fell(event_active));
endmodule
bind vdrt_top vdrt_asserts chk_u (.*);
`default_nettype wire

// File: tb/vdrt_partner.sv
`timescale 1ns/1ps
`default_nettype none
// Voltage meter and alarm sources; registered, as real sampled measurements are.
module vdrt_partner (
    input wire logic aclk,
    input wire logic [15:0] volt_set,
    input wire logic [15:0] alarm_set,
    output var logic [15:0] gen_voltage,
    output var logic [15:0] trip_alarm_cond
);
    always @(posedge aclk) begin
        gen_voltage <= volt_set;
        trip_alarm_cond <= alarm_set;
    end
endmodule
`default_nettype wire

// File: tb/vdrt_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "vdrt_defines.vh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
    $display("Error t=%0t got %h exp %h", $time, a, b); end end
module vdrt_tb_top;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, mains_parallel = 0, gens_parallel = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic event_active, gen_low_voltage_alarm, suppress_low_voltage;
    logic gen_low_voltage_cond = 0;
    logic [15:0] gen_voltage, trip_alarm_cond, trip_suppress_mask, warning_suppress_mask;
    logic [15:0] trip_alarm_out, volt_set = 16'h0600, alarm_set = 16'hffff;
    int failures = 0, n_checks = 0, cyc = 0;
    vdrt_top dut_u (.*);
    vdrt_partner src_u (.*);
    always #2 aclk = ~aclk;
    task automatic conclude;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // The whole run needs about 3100 cycles; a hung handshake is cut off here.
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 8000) begin
            failures++;
            conclude;
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a; s_axi_wdata <= d;
        s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 0;
    endtask
    task automatic rdw(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ed);
        @(posedge aclk);
        s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        s_axi_rready <= 0;
        `CHK(s_axi_rresp, er)
        `CHK(rd, ed)
    endtask
    task automatic t_reset;
        `CHK(event_active, 1'b0)
        rdw(`VDRT_CTRL, 2'b00, `VDRT_CTRL_RESET);
        rdw(8'h3c, 2'b10, 32'h0000_0000);
        $display("t_reset done");
    endtask
    task automatic t_ride;
        for (int i = 0; i < 5; i++) begin
            wr(`VDRT_V0 + 8'(4 * i), 32'(16'h0100 * (i + 1)));
            wr(`VDRT_T0 + 8'(4 * i), 32'(i + 1));
        end
        wr(`VDRT_TDELAY, 32'h0000_000a);
        wr(`VDRT_MASK, 32'h0000_0003);
        wr(`VDRT_CTRL, 32'h0000_0003);
        gens_parallel <= 1; volt_set <= 16'h0450;
        repeat (20) @(posedge aclk);
        `CHK(event_active, 1'b0)
        mains_parallel <= 1;
        repeat (5) @(posedge aclk);
        `CHK(event_active, 1'b1)
        `CHK(trip_suppress_mask, 16'hffff)
        `CHK(trip_alarm_out, 16'h0000)
        `CHK(warning_suppress_mask, 16'h0000)
        `CHK(irq, 1'b1)
        volt_set <= 16'h0150;
        repeat (5) @(posedge aclk);
        `CHK(suppress_low_voltage, 1'b1)
        repeat (300) @(posedge aclk);
        `CHK(suppress_low_voltage, 1'b0)
        `CHK(gen_low_voltage_alarm, 1'b1)
        volt_set <= 16'h0600;
        repeat (1300) @(posedge aclk);
        `CHK(event_active, 1'b0)
        `CHK(gen_low_voltage_alarm, 1'b0)
        rdw(`VDRT_COUNT, 2'b00, 32'h0000_0001);
        $display("t_ride done");
    endtask
    task automatic t_expire;
        volt_set <= 16'h0450;
        repeat (1400) @(posedge aclk);
        `CHK(event_active, 1'b1)
        `CHK(trip_suppress_mask, 16'h0000)
        `CHK(trip_alarm_out, 16'hffff)
        volt_set <= 16'h0600;
        repeat (5) @(posedge aclk);
        `CHK(event_active, 1'b0)
        rdw(`VDRT_COUNT, 2'b00, 32'h0000_0002);
        wr(`VDRT_CTRL, 32'h0000_000b);
        rdw(`VDRT_COUNT, 2'b00, 32'h0000_0000);
        wr(`VDRT_STATUS, 32'h0000_0003);
        repeat (2) @(posedge aclk);
        `CHK(irq, 1'b0)
        wr(`VDRT_CTRL, 32'h0000_0005);
        mains_parallel <= 0; volt_set <= 16'h0450;
        repeat (5) @(posedge aclk);
        `CHK(event_active, 1'b1)
        $display("t_expire done");
    endtask
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        t_reset;
        t_ride;
        t_expire;
        conclude;
    end
endmodule
`default_nettype wire
